//--- include/lof_pkg.sv
package lof_pkg;

   // System clock and the delays it times.
   localparam int unsigned CLK_HZ             = 100_000_000;
   localparam int unsigned CYC_PER_MS         = CLK_HZ / 1000;
   localparam int unsigned FAULT_RESTART_MS   = 100;
   localparam int unsigned AUTO_RESTART_MS    = 14;
   localparam int unsigned FAULT_RESTART_CYC  = FAULT_RESTART_MS * CYC_PER_MS;
   localparam int unsigned AUTO_RESTART_CYC   = AUTO_RESTART_MS * CYC_PER_MS;
   localparam int unsigned CNT_W              = 24;

   // Widths.
   localparam int unsigned NCH                = 2;
   localparam int unsigned CUR_W              = 8;
   localparam int unsigned EV_W               = 6;

   // Register byte offsets.
   localparam logic [11:0] ADDR_CTRL          = 12'h000;
   localparam logic [11:0] ADDR_THRESH        = 12'h004;
   localparam logic [11:0] ADDR_OC_STATUS     = 12'h008;
   localparam logic [11:0] ADDR_STATE         = 12'h00C;
   localparam logic [11:0] ADDR_EV_STATUS     = 12'h010;
   localparam logic [11:0] ADDR_EV_MASK       = 12'h014;

   // Control register field positions and reset values.
   localparam int unsigned CTRL_SDDIS_LSB     = 0;
   localparam int unsigned CTRL_OCMASK_LSB    = 2;
   localparam int unsigned CTRL_UVMASK_LSB    = 4;
   localparam int unsigned CTRL_PGIE_LSB      = 6;
   localparam int unsigned CTRL_ON_LSB        = 8;
   localparam logic [1:0]  SDDIS_RST          = 2'h0;
   localparam logic [1:0]  OCMASK_RST         = 2'h0;
   localparam logic [1:0]  UVMASK_RST         = 2'h0;
   localparam logic [1:0]  PGIE_RST           = 2'h0;
   localparam logic [1:0]  ON_RST             = 2'h3;

   // Threshold register layout.
   localparam int unsigned THR_A_LSB          = 0;
   localparam int unsigned THR_B_LSB          = 8;
   localparam logic [7:0]  THR_RST            = 8'h80;

   // Overcurrent status and state register layout.
   localparam int unsigned OCS_FLAG_LSB       = 0;
   localparam int unsigned OCS_PG_LSB         = 2;
   localparam int unsigned OCS_FAULT_BIT      = 4;
   localparam int unsigned ST_SYS_LSB         = 0;
   localparam int unsigned ST_EN_LSB          = 2;
   localparam int unsigned ST_LIM_LSB         = 4;
   localparam int unsigned ST_UV_LSB          = 6;
   localparam int unsigned ST_PEND_LSB        = 8;

   // Event bits of the sticky status and mask registers.
   localparam int unsigned EV_OC_LSB          = 0;
   localparam int unsigned EV_UV_LSB          = 2;
   localparam int unsigned EV_FAULT_BIT       = 4;
   localparam int unsigned EV_RESTART_BIT     = 5;
   localparam logic [5:0]  EV_MASK_RST        = 6'h00;

   typedef enum logic [1:0] {
      SYS_RUN     = 2'b00,
      SYS_FAULT   = 2'b01,
      SYS_RESTART = 2'b10
   } lof_sys_e;

   typedef enum logic [2:0] {
      CH_DIS      = 3'b000,
      CH_ON       = 3'b001,
      CH_LIMIT    = 3'b010,
      CH_OFF_WAIT = 3'b011,
      CH_OFF_HOLD = 3'b100
   } lof_ch_e;

   typedef struct packed {
      lof_ch_e            st;
      logic [CNT_W-1:0]   cnt;
   } lof_chan_s;

endpackage : lof_pkg

//--- rtl/lof_fault_mgr.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Each regulator has a limit_shutdown_disable bit: clear means an overcurrent turns it off, set means it keeps limiting until the overload ends.
// - Each regulator has its own programmable current threshold and its load current is compared against that threshold only.
// - Reaching the threshold sets that regulator's overcurrent_status_flag, which holds until a host read of it clears it.
// - Overcurrent and the undervoltage it may cause form one fault source; undervoltage without overcurrent, limiting or a held shutdown never triggers it.
// - An unmasked undervoltage caused by current limiting turns off all supplies, drives interrupt_out_n low and enters the voltage fault state.
// - In the voltage fault state the block waits 100 ms and then restarts every supply whose on bit is set, pulsing restart_seq.
// - With the overcurrent fault mask set, the regulator still shuts off or limits current as its shutdown-disable bit selects.
// - With the overcurrent fault mask set, an overcurrent or short on that regulator never enters the voltage fault state.
// - A masked regulator turned off by its current limit is re-enabled automatically 14 ms later.
// - An unmasked power-good interrupt holds interrupt_out_n low until the regulator is off or back in regulation and its power_good_bit was read.
module lof_fault_mgr
   import lof_pkg::*;
#(
   parameter int unsigned FAULT_CYC = FAULT_RESTART_CYC,
   parameter int unsigned AUTO_CYC  = AUTO_RESTART_CYC
)
(
   input  wire  logic               pclk,
   input  wire  logic               presetn,
   input  wire  logic               clk_en,
   input  wire  logic               psel,
   input  wire  logic               penable,
   input  wire  logic               pwrite,
   input  wire  logic [11:0]        paddr,
   input  wire  logic [31:0]        pwdata,
   output var   logic               pready,
   output var   logic [31:0]        prdata,
   output var   logic               pslverr,
   input  wire  logic [CUR_W-1:0]   load_current_a,
   input  wire  logic [CUR_W-1:0]   load_current_b,
   input  wire  logic               undervolt_a,
   input  wire  logic               undervolt_b,
   output var   logic [NCH-1:0]     reg_enable,
   output var   logic [NCH-1:0]     limit_active,
   output var   logic               supplies_off,
   output var   logic               restart_seq,
   output var   logic               interrupt_out_n,
   output var   logic               irq
);

   // Whole state of the block, registered as one word.
   typedef struct packed {
      logic [NCH-1:0][CUR_W-1:0] cur_m;
      logic [NCH-1:0][CUR_W-1:0] cur_s;
      logic [NCH-1:0]            uv_m;
      logic [NCH-1:0]            uv_s;
      logic [NCH-1:0]            uv_p;
      logic [NCH-1:0]            sd_dis;
      logic [NCH-1:0]            oc_mask;
      logic [NCH-1:0]            uv_mask;
      logic [NCH-1:0]            pg_ie;
      logic [NCH-1:0]            on;
      logic [NCH-1:0][CUR_W-1:0] thr;
      logic [NCH-1:0]            over;
      logic [NCH-1:0]            oc_flag;
      logic [NCH-1:0]            pg_pend;
      logic [NCH-1:0]            pg_read;
      logic                      fault_irq;
      logic [EV_W-1:0]           ev;
      logic [EV_W-1:0]           ev_mask;
      lof_sys_e                  sys;
      logic [CNT_W-1:0]          sys_cnt;
      lof_chan_s [NCH-1:0]       ch;
      logic                      pready;
      logic [31:0]               prdata;
      logic                      pslverr;
      logic [NCH-1:0]            reg_en;
      logic [NCH-1:0]            lim;
      logic                      supplies_off;
      logic                      restart;
      logic                      intn;
      logic                      irq;
   } lof_state_s;

   localparam logic [CNT_W-1:0] FAULT_LOAD = CNT_W'(FAULT_CYC - 1);
   localparam logic [CNT_W-1:0] AUTO_LOAD  = CNT_W'(AUTO_CYC - 1);

   lof_state_s         s_q;
   lof_state_s         s_d;
   logic               acc_start;
   logic               acc_done;
   logic               wr;
   logic               rd;
   logic               oc_read;
   logic [NCH-1:0]     over_now;
   logic [NCH-1:0]     fault_trig;
   logic [NCH-1:0]     below;
   logic [EV_W-1:0]    ev_set;
   logic [31:0]        rdata;
   logic               addr_ok;

   // Steps one regulator's protection state; shared by both channels.
   function automatic lof_chan_s lof_ch_step(input lof_chan_s c, input logic on, input logic over,
                                             input logic sd_dis, input logic ocm);
      lof_chan_s r;
      r = c;
      if (!on)
      begin
         r.st  = CH_DIS;
         r.cnt = '0;
      end
      else
      begin
         case (c.st)
            CH_DIS:
            begin
               r.st = CH_ON;
            end
            CH_ON, CH_LIMIT:
            begin
               if (over)
               begin
                  if (sd_dis)
                  begin
                     r.st = CH_LIMIT;
                  end
                  else if (ocm)
                  begin
                     r.st  = CH_OFF_WAIT;
                     r.cnt = AUTO_LOAD;
                  end
                  else
                  begin
                     r.st = CH_OFF_HOLD;
                  end
               end
               else
               begin
                  r.st = CH_ON;
               end
            end
            CH_OFF_WAIT:
            begin
               if (c.cnt == '0)
               begin
                  r.st = CH_ON;
               end
               else
               begin
                  r.cnt = c.cnt - 1'b1;
               end
            end
            CH_OFF_HOLD:
            begin
               r.st = CH_OFF_HOLD;
            end
            default:
            begin
               r.st = CH_DIS;
            end
         endcase
      end
      return r;
   endfunction : lof_ch_step

   // APB phase decode: one wait state, then the access completes.
   assign acc_start = psel & penable & ~s_q.pready;
   assign acc_done  = psel & penable & s_q.pready;
   assign wr        = acc_done & pwrite;
   assign rd        = acc_done & ~pwrite;
   assign oc_read   = rd & (paddr == ADDR_OC_STATUS);

   // Read data mux and address check.
   always_comb
   begin
      rdata   = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         ADDR_CTRL:
         begin
            rdata[CTRL_SDDIS_LSB +: NCH]  = s_q.sd_dis;
            rdata[CTRL_OCMASK_LSB +: NCH] = s_q.oc_mask;
            rdata[CTRL_UVMASK_LSB +: NCH] = s_q.uv_mask;
            rdata[CTRL_PGIE_LSB +: NCH]   = s_q.pg_ie;
            rdata[CTRL_ON_LSB +: NCH]     = s_q.on;
         end
         ADDR_THRESH:
         begin
            rdata[THR_A_LSB +: CUR_W] = s_q.thr[0];
            rdata[THR_B_LSB +: CUR_W] = s_q.thr[1];
         end
         ADDR_OC_STATUS:
         begin
            rdata[OCS_FLAG_LSB +: NCH] = s_q.oc_flag;
            rdata[OCS_PG_LSB +: NCH]   = ~s_q.uv_s;
            rdata[OCS_FAULT_BIT]       = s_q.fault_irq;
         end
         ADDR_STATE:
         begin
            rdata[ST_SYS_LSB +: 2]   = s_q.sys;
            rdata[ST_EN_LSB +: NCH]  = s_q.reg_en;
            rdata[ST_LIM_LSB +: NCH] = s_q.lim;
            rdata[ST_UV_LSB +: NCH]  = s_q.uv_s;
            rdata[ST_PEND_LSB +: NCH] = s_q.pg_pend;
         end
         ADDR_EV_STATUS:
         begin
            rdata[EV_W-1:0] = s_q.ev;
         end
         ADDR_EV_MASK:
         begin
            rdata[EV_W-1:0] = s_q.ev_mask;
         end
         default:
         begin
            addr_ok = 1'b0;
         end
      endcase
   end

   // Next-state logic of the whole block.
   always_comb
   begin
      s_d        = s_q;
      over_now   = '0;
      fault_trig = '0;
      below      = '0;

      // Two-stage synchronisers for the analog-side inputs.
      s_d.cur_m[0] = load_current_a;
      s_d.cur_m[1] = load_current_b;
      s_d.cur_s    = s_q.cur_m;
      s_d.uv_m     = {undervolt_b, undervolt_a};
      s_d.uv_s     = s_q.uv_m;
      s_d.uv_p     = s_q.uv_s; // Previous synchronised level, for edge detection only.

      // Bus answer, registered so it appears one cycle into the access phase.
      s_d.pready  = acc_start;
      s_d.pslverr = acc_start & ~addr_ok;
      s_d.prdata  = (acc_start & ~pwrite) ? rdata : 32'h0000_0000;

      // Register writes.
      if (wr)
      begin
         case (paddr)
            ADDR_CTRL:
            begin
               s_d.sd_dis  = pwdata[CTRL_SDDIS_LSB +: NCH];
               s_d.oc_mask = pwdata[CTRL_OCMASK_LSB +: NCH];
               s_d.uv_mask = pwdata[CTRL_UVMASK_LSB +: NCH];
               s_d.pg_ie   = pwdata[CTRL_PGIE_LSB +: NCH];
               s_d.on      = pwdata[CTRL_ON_LSB +: NCH];
            end
            ADDR_THRESH:
            begin
               s_d.thr[0] = pwdata[THR_A_LSB +: CUR_W];
               s_d.thr[1] = pwdata[THR_B_LSB +: CUR_W];
            end
            ADDR_EV_MASK:
            begin
               s_d.ev_mask = pwdata[EV_W-1:0];
            end
            default:
            begin
               s_d.ev_mask = s_q.ev_mask;
            end
         endcase
      end

      // Per-regulator detection: each load against its own threshold.
      for (int i = 0; i < NCH; i++)
      begin
         over_now[i]   = s_q.on[i] & (s_q.cur_s[i] >= s_q.thr[i]);
         // Only undervoltage during overcurrent, limiting or a latched overcurrent shutdown counts, and only unmasked.
         fault_trig[i] = s_q.uv_s[i] & ~s_q.uv_mask[i] & ~s_q.oc_mask[i]
                         & (over_now[i] | (s_q.ch[i].st == CH_LIMIT) | (s_q.ch[i].st == CH_OFF_HOLD));
         below[i]      = s_q.uv_s[i] & s_q.reg_en[i];
      end
      s_d.over = over_now;

      // Latched overcurrent flags: a read clears them, a new event wins.
      s_d.oc_flag = (oc_read ? '0 : s_q.oc_flag) | over_now;

      // Power-good interrupt hold per regulator.
      for (int i = 0; i < NCH; i++)
      begin
         if (s_q.pg_ie[i] & below[i] & ~s_q.pg_pend[i])
         begin
            s_d.pg_pend[i] = 1'b1;
            s_d.pg_read[i] = 1'b0;
         end
         else if (s_q.pg_pend[i])
         begin
            if (oc_read)
            begin
               s_d.pg_read[i] = 1'b1;
            end
            if ((s_q.pg_read[i] | oc_read) & (~s_q.reg_en[i] | ~s_q.uv_s[i]))
            begin
               s_d.pg_pend[i] = 1'b0;
               s_d.pg_read[i] = 1'b0;
            end
         end
      end

      // Global supervisor: voltage fault state and timed restart.
      case (s_q.sys)
         SYS_RUN:
         begin
            if (|fault_trig)
            begin
               s_d.sys     = SYS_FAULT;
               s_d.sys_cnt = FAULT_LOAD;
            end
         end
         SYS_FAULT:
         begin
            if (s_q.sys_cnt == '0)
            begin
               s_d.sys = SYS_RESTART;
            end
            else
            begin
               s_d.sys_cnt = s_q.sys_cnt - 1'b1;
            end
         end
         SYS_RESTART:
         begin
            s_d.sys = SYS_RUN;
         end
         default:
         begin
            s_d.sys = SYS_RUN;
         end
      endcase

      // The fault interrupt latch clears on the status read; entry wins.
      s_d.fault_irq = (oc_read ? 1'b0 : s_q.fault_irq) | (s_d.sys == SYS_FAULT && s_q.sys == SYS_RUN);

      // Regulator protection channels, each with its own restart counter.
      for (int i = 0; i < NCH; i++)
      begin
         if (s_d.sys == SYS_FAULT)
         begin
            s_d.ch[i].st  = CH_DIS;
            s_d.ch[i].cnt = '0;
         end
         else if (s_q.sys == SYS_RESTART)
         begin
            s_d.ch[i].st  = s_q.on[i] ? CH_ON : CH_DIS;
            s_d.ch[i].cnt = '0;
         end
         else
         begin
            s_d.ch[i] = lof_ch_step(s_q.ch[i], s_q.on[i], over_now[i], s_q.sd_dis[i], s_q.oc_mask[i]);
         end
         s_d.reg_en[i] = (s_d.sys == SYS_RUN) & ((s_d.ch[i].st == CH_ON) | (s_d.ch[i].st == CH_LIMIT));
         s_d.lim[i]    = (s_d.sys == SYS_RUN) & (s_d.ch[i].st == CH_LIMIT);
      end

      // Sticky event status, write one to clear, a new event wins.
      ev_set                          = '0;
      ev_set[EV_OC_LSB +: NCH]        = over_now & ~s_q.over;
      ev_set[EV_UV_LSB +: NCH]        = s_q.uv_s & ~s_q.uv_p;
      ev_set[EV_FAULT_BIT]            = (s_q.sys == SYS_RUN) & (|fault_trig);
      ev_set[EV_RESTART_BIT]          = (s_q.sys == SYS_RESTART);
      if (wr && paddr == ADDR_EV_STATUS)
      begin
         s_d.ev = (s_q.ev & ~pwdata[EV_W-1:0]) | ev_set;
      end
      else
      begin
         s_d.ev = s_q.ev | ev_set;
      end

      // Registered outputs.
      s_d.supplies_off = (s_d.sys == SYS_FAULT);
      s_d.restart      = (s_d.sys == SYS_RESTART);
      s_d.irq          = |(s_d.ev & s_d.ev_mask);
      s_d.intn         = ~(|(s_d.oc_flag & ~s_d.oc_mask) | (|s_d.pg_pend) | s_d.fault_irq);
   end

   // State register; the clock enable freezes everything.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q         <= '0;
         s_q.sd_dis  <= SDDIS_RST;
         s_q.oc_mask <= OCMASK_RST;
         s_q.uv_mask <= UVMASK_RST;
         s_q.pg_ie   <= PGIE_RST;
         s_q.on      <= ON_RST;
         s_q.thr     <= {THR_RST, THR_RST};
         s_q.ev_mask <= EV_MASK_RST;
         s_q.sys     <= SYS_RUN;
         s_q.intn    <= 1'b1;
      end
      else if (clk_en)
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register.
   assign pready          = s_q.pready;
   assign prdata          = s_q.prdata;
   assign pslverr         = s_q.pslverr;
   assign reg_enable      = s_q.reg_en;
   assign limit_active    = s_q.lim;
   assign supplies_off    = s_q.supplies_off;
   assign restart_seq     = s_q.restart;
   assign interrupt_out_n = s_q.intn;
   assign irq             = s_q.irq;

endmodule : lof_fault_mgr

`default_nettype wire

//--- dv/lof_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the regulator fault manager.
module lof_checker
   import lof_pkg::*;
#(
   parameter int unsigned FAULT_CYC = 20
)
(
   input wire logic           pclk,
   input wire logic           presetn,
   input wire logic           clk_en,
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pready,
   input wire logic [31:0]    prdata,
   input wire logic           pslverr,
   input wire logic [NCH-1:0] reg_enable,
   input wire logic [NCH-1:0] limit_active,
   input wire logic           supplies_off,
   input wire logic           restart_seq,
   input wire logic           interrupt_out_n
);
   localparam int F_LO = FAULT_CYC - 1;
   localparam int F_HI = FAULT_CYC + 1;
   // All checks run on the system clock and pause during reset.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Bus answer comes after one wait state, lasts one cycle, and read data is zero otherwise.
   property p_rdy_wait; psel && !penable && clk_en |=> !pready ##1 pready; endproperty
   a_rdy_wait: assert property (p_rdy_wait) else $error("ready not after one wait state");
   property p_rdy_pulse; pready |=> !pready; endproperty
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready longer than one cycle");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
   property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
   // Fault shutdown drops every supply, pulls the interrupt low and restarts after the delay.
   property p_off_irq; $rose(supplies_off) |-> ##[0:1] !interrupt_out_n; endproperty
   a_off_irq: assert property (p_off_irq) else $error("fault without interrupt");
   property p_off_dis; supplies_off && $past(supplies_off) |-> reg_enable == 2'b00; endproperty
   a_off_dis: assert property (p_off_dis) else $error("supply on during fault");
   property p_off_hold; $rose(supplies_off) |-> supplies_off [*8]; endproperty
   a_off_hold: assert property (p_off_hold) else $error("fault state left early");
   property p_restart_time; $rose(supplies_off) |-> ##[F_LO:F_HI] restart_seq; endproperty
   a_restart_time: assert property (p_restart_time) else $error("restart delay wrong");
   property p_restart_pulse; restart_seq |=> !restart_seq && !supplies_off; endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("restart not a single pulse");
   // A limiting regulator keeps its output on.
   property p_limit_on; (limit_active & ~reg_enable) == 2'b00; endproperty
   a_limit_on: assert property (p_limit_on) else $error("limiting with output off");
endmodule : lof_checker
`default_nettype wire

//--- dv/lof_host.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master standing in for the host processor.
module lof_host
   import lof_pkg::*;
(
   input wire logic        pclk,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   output var logic        psel,
   output var logic        penable,
   output var logic        pwrite,
   output var logic [11:0] paddr,
   output var logic [31:0] pwdata
);
   // Idle bus at time zero.
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'hFFF;
      pwdata = 32'h0;
   end
   // One transfer; released address and data lines carry the inverse of the last value, while pwrite keeps its last value.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output bit ok);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; n < 16 && pready !== 1'b1; n++)
         @(posedge pclk);
      ok = (n < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask : xfer
endmodule : lof_host
`default_nettype wire

//--- dv/lof_fault_mgr_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the regulator fault manager.
module lof_fault_mgr_tb
   import lof_pkg::*;
;
   localparam int FC = 20;
   localparam int AC = 8;
   logic              pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
   logic              undervolt_a, undervolt_b, supplies_off, restart_seq, interrupt_out_n, irq;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata;
   logic [CUR_W-1:0]  load_current_a, load_current_b, thr_a;
   logic [NCH-1:0]    reg_enable, limit_active;
   int                err_count = 0;
   int                checks = 0;
   int                n;
   int                mdl [int];
   // System clock.
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;
   lof_fault_mgr #(.FAULT_CYC(FC), .AUTO_CYC(AC)) lof_fault_mgr_i (.pclk, .presetn, .clk_en, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .load_current_a, .load_current_b, .undervolt_a,
      .undervolt_b, .reg_enable, .limit_active, .supplies_off, .restart_seq, .interrupt_out_n, .irq);
   lof_host lof_host_i (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);
   // Compares one result and counts it.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk
   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   // One bus access; read data is masked and compared.
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic        e;
      bit          ok;
      lof_host_i.xfer(w, a, d, q, e, ok);
      chk({31'h0, ok}, 32'h1, "bus answer");
      if (!ok)
         end_sim();
      if (!w)
         chk(q & m, x, "read data");
      chk({31'h0, e}, {31'h0, xe}, "slave error");
   endtask : acc
   // Write that also updates the register model.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      mdl[a] = d;
      acc(1'b1, a, d, 32'h0, 32'h0, 1'b0);
   endtask : wr
   // Read compared with the register model.
   task automatic rdm(input logic [11:0] a);
      acc(1'b0, a, 32'h0, 32'hFFFFFFFF, mdl[a], 1'b0);
   endtask : rdm
   // Selects an observed output for a bounded wait.
   function automatic logic [1:0] pick(input int s);
      case (s)
         0: return limit_active;
         1: return reg_enable;
         2: return {1'b0, supplies_off};
         3: return {1'b0, restart_seq};
         4: return {1'b0, irq};
         default: return {1'b0, interrupt_out_n};
      endcase
   endfunction : pick
   // Waits a bounded number of edges for an output value; n keeps the edge count.
   task automatic wfor(input int s, input logic [1:0] v, input int lim);
      for (n = 0; n < lim && pick(s) !== v; n++)
         @(posedge pclk);
      chk(pick(s), v, "awaited output");
      if (n >= lim)
         end_sim();
   endtask : wfor
   // Guard against a hung run.
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_count++;
      end_sim();
   end
   // Main sequence.
   initial
   begin
      void'($urandom(71));
      {presetn, undervolt_a, undervolt_b, load_current_a, load_current_b} = '0;
      clk_en = 1'b1;
      mdl[ADDR_CTRL] = 32'h300;
      mdl[ADDR_THRESH] = 32'h8080;
      mdl[ADDR_EV_MASK] = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rdm(ADDR_CTRL);
      rdm(ADDR_THRESH);
      rdm(ADDR_EV_MASK);
      chk(reg_enable, 2'b11, "enabled after reset");
      acc(1'b0, 12'h018, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
      $display("test registers done");
      thr_a = 8'h20 + 8'($urandom % 64);
      wr(ADDR_THRESH, {16'h0, thr_a + 8'h01, thr_a});
      rdm(ADDR_THRESH);
      wr(ADDR_CTRL, 32'h30F);
      load_current_a <= thr_a;
      load_current_b <= thr_a;
      wfor(0, 2'b01, 10);
      chk(reg_enable, 2'b11, "limit keeps output on");
      acc(1'b0, ADDR_OC_STATUS, 32'h0, 32'h3, 32'h1, 1'b0);
      load_current_a <= 8'h00;
      wfor(0, 2'b00, 10);
      acc(1'b0, ADDR_OC_STATUS, 32'h0, 32'h3, 32'h1, 1'b0);
      acc(1'b0, ADDR_OC_STATUS, 32'h0, 32'h3, 32'h0, 1'b0);
      $display("test current limit done");
      wr(ADDR_CTRL, 32'h304);
      load_current_a <= thr_a;
      wfor(1, 2'b10, 10);
      chk(limit_active, 2'b00, "shut off, not limiting");
      load_current_a <= 8'h00;
      wfor(1, 2'b11, AC + 10);
      chk({31'h0, n + 2 >= AC && n <= AC + 1}, 32'h1, "auto restart delay");
      $display("test auto restart done");
      wr(ADDR_CTRL, 32'h30F);
      load_current_b <= 8'hFF;
      undervolt_b <= 1'b1;
      repeat (FC) @(posedge pclk);
      chk(supplies_off, 1'b0, "masked overload");
      chk(limit_active, 2'b10, "masked limit");
      wr(ADDR_CTRL, 32'h303);
      wfor(2, 2'b01, 10);
      load_current_b <= 8'h00;
      undervolt_b <= 1'b0;
      @(posedge pclk);
      chk(interrupt_out_n, 1'b0, "fault interrupt");
      chk(reg_enable, 2'b00, "all supplies off");
      wfor(3, 2'b01, FC + 10);
      chk({31'h0, n + 3 >= FC && n <= FC + 1}, 32'h1, "fault restart delay");
      wfor(1, 2'b11, 10);
      acc(1'b0, ADDR_EV_STATUS, 32'h0, 32'h10, 32'h10, 1'b0);
      chk(irq, 1'b0, "masked event");
      wr(ADDR_EV_MASK, 32'h10);
      wfor(4, 2'b01, 4);
      wr(ADDR_EV_STATUS, 32'h10);
      wfor(4, 2'b00, 4);
      rdm(ADDR_EV_MASK);
      acc(1'b0, ADDR_OC_STATUS, 32'h0, 32'h10, 32'h10, 1'b0);
      wfor(5, 2'b01, 6);
      $display("test voltage fault done");
      wr(ADDR_CTRL, 32'h343);
      undervolt_a <= 1'b1;
      wfor(5, 2'b00, 10);
      chk(supplies_off, 1'b0, "undervoltage alone");
      undervolt_a <= 1'b0;
      repeat (8) @(posedge pclk);
      chk(interrupt_out_n, 1'b0, "held until read");
      acc(1'b0, ADDR_OC_STATUS, 32'h0, 32'hC, 32'hC, 1'b0);
      wfor(5, 2'b01, 6);
      $display("test power good done");
      // A low clock enable must hold off the limit response until it returns.
      clk_en <= 1'b0;
      load_current_a <= thr_a;
      repeat (6) @(posedge pclk);
      chk(limit_active, 2'b00, "frozen by clock enable");
      clk_en <= 1'b1;
      wfor(0, 2'b01, 10);
      $display("test clock enable done");
      end_sim();
   end
endmodule : lof_fault_mgr_tb
bind lof_fault_mgr lof_checker #(.FAULT_CYC(FAULT_CYC)) lof_checker_i (.pclk, .presetn, .clk_en, .psel,
   .penable, .pready, .prdata, .pslverr, .reg_enable, .limit_active, .supplies_off, .restart_seq, .interrupt_out_n);
`default_nettype wire
